// >>> core/e3_lapd_pkg.sv
// constants and types for the e3 receive link message capture block
package e3_lapd_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h19;
  localparam logic [7:0] ADDR_NR = 8'h1A;
  localparam logic [7:0] ADDR_GC = 8'h1B;
  localparam logic [7:0] ADDR_TT0 = 8'h1C;
  localparam logic [7:0] ADDR_TT1 = 8'h1D;
  localparam int CTL_SRC = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 1;
  localparam int CTL_IRQ = 0;
  localparam int ST_ABORT = 6;
  localparam int ST_KIND = 4;
  localparam int ST_CR = 3;
  localparam int ST_FCS = 2;
  localparam int ST_EOM = 1;
  localparam int ST_FLAG = 0;
  localparam int HDR_CR_BIT = 1;
  localparam int TT_MARK_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] FLAG_ONES = 3'h6;
  localparam logic [2:0] ABORT_ONES = 3'h7;
  localparam logic [3:0] OCTET_BITS = 4'h8;
  localparam logic [7:0] HDR_CR_OCT = 8'h01;
  localparam logic [7:0] HDR_KIND_OCT = 8'h04;
  localparam logic [7:0] MIN_OCTETS = 8'h06;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [1:0] TT_FIRST = 2'h0;
  localparam logic [1:0] TT_SECOND = 2'h1;
  localparam logic [1:0] TT_DONE = 2'h2;

  typedef enum logic [1:0] {
    KIND_CL_PATH,
    KIND_IDLE,
    KIND_TEST,
    KIND_ITU_PATH
  } message_kind_e;

  typedef struct packed {
    logic valid;
    logic [7:0] nr;
    logic [7:0] gc;
    logic [7:0] tr;
  } e3_overhead_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// >>> core/e3_rx_lapd_overhead_capture.sv
// e3 receive overhead capture: link message receiver and byte captures
// What this block does
// - source bit picks operator or general byte
// - receiver ignores messages while disabled
// - interrupt output only when enabled
// - complete message sets interrupt status bit
// - control read clears interrupt status bit
// - seven ones set the abort indicator
// - two-bit field reports received message kind
// - show command/response bit of latest message
// - flag bad check sequence of latest message
// - end-of-message set when message completes
// - end-of-message clears after new valid header
// - flag-present follows 7Eh in selected byte
// - capture operator byte every frame
// - capture general channel byte every frame
// - first trace register holds start marker
// - marker found by set top bit
// - second trace register holds following byte
// - later trace bytes are not captured
module e3_rx_lapd_overhead_capture
  import e3_lapd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire e3_overhead_s ovh_i,
  input wire reg_req_s req_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  typedef enum logic {HUNT, IN_FRAME} rx_state_e;

  rx_state_e state, next_state;
  logic src_nr, next_src_nr;
  logic rx_en, next_rx_en;
  logic irq_en, next_irq_en;
  logic irq_flag, next_irq_flag;
  logic abort, next_abort;
  message_kind_e kind, next_kind;
  logic cr, next_cr;
  logic fcs_err, next_fcs_err;
  logic message_done, next_eom;
  logic flag_seen, next_flag_seen;
  logic [7:0] nr_cap, next_nr_cap;
  logic [7:0] gc_cap, next_gc_cap;
  logic [7:0] tt0, next_tt0;
  logic [7:0] tt1, next_tt1;
  logic [1:0] tt_pos, next_tt_pos;
  logic [7:0] shreg, next_shreg;
  logic [3:0] shcnt, next_shcnt;
  logic [2:0] ones, next_ones;
  logic [7:0] octet, next_octet;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] octcnt, next_octcnt;
  logic [15:0] crc, next_crc;
  logic [15:0] crc_oct, next_crc_oct;
  logic [7:0] rdata, next_rdata;
  logic irq_q, next_irq_q;
  logic msg_end;
  logic hdr_done;
  logic bit_take;
  logic [7:0] sel_byte;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic addr_hit(input reg_req_s r,
                                    input logic [7:0] a);
    addr_hit = r.addr == a;
  endfunction

  // overhead capture and serialiser
  always_comb
  begin
    sel_byte = src_nr ? ovh_i.nr : ovh_i.gc;
    next_shreg = shreg;
    next_shcnt = shcnt;
    next_nr_cap = nr_cap;
    next_gc_cap = gc_cap;
    next_tt0 = tt0;
    next_tt1 = tt1;
    next_tt_pos = tt_pos;
    next_flag_seen = flag_seen;
    bit_take = 1'b0;
    if (ovh_i.valid && shcnt == 4'h0)
    begin
      next_shreg = sel_byte;
      next_shcnt = OCTET_BITS;
      next_flag_seen = sel_byte == FLAG_OCTET;
      next_nr_cap = ovh_i.nr;
      next_gc_cap = ovh_i.gc;
      if (ovh_i.tr[TT_MARK_BIT])
      begin
        next_tt0 = ovh_i.tr;
        next_tt_pos = TT_SECOND;
      end
      else if (tt_pos == TT_SECOND)
      begin
        next_tt1 = ovh_i.tr;
        next_tt_pos = TT_DONE;
      end
    end
    else if (shcnt != 4'h0)
    begin
      bit_take = 1'b1;
      next_shreg = shreg >> 1;
      next_shcnt = shcnt - 4'h1;
    end
  end

  // bit level link message receiver
  always_comb
  begin
    next_state = state;
    next_ones = ones;
    next_octet = octet;
    next_bitcnt = bitcnt;
    next_octcnt = octcnt;
    next_crc = crc;
    next_crc_oct = crc_oct;
    next_abort = abort;
    next_kind = kind;
    next_cr = cr;
    next_fcs_err = fcs_err;
    next_eom = message_done;
    msg_end = 1'b0;
    hdr_done = 1'b0;
    if (!rx_en)
    begin
      next_state = HUNT;
      next_ones = 3'h0;
    end
    else if (bit_take && shreg[0])
    begin
      if (ones != ABORT_ONES)
        next_ones = ones + 3'h1;
      if (ones == FLAG_ONES)
      begin
        next_abort = 1'b1;
        next_state = HUNT;
      end
      else if (state == IN_FRAME)
      begin
        next_octet = {1'b1, octet[7:1]};
        next_crc = crc_step(crc, 1'b1);
        next_bitcnt = bitcnt + 4'h1;
      end
    end
    else if (bit_take)
    begin
      next_ones = 3'h0;
      if (ones == FLAG_ONES)
      begin
        // flag bits were shifted in: use residue of last whole octet
        if (state == IN_FRAME && bitcnt == OCTET_BITS - 4'h1 &&
            octcnt >= MIN_OCTETS)
        begin
          msg_end = 1'b1;
          next_eom = 1'b1;
          next_fcs_err = crc_oct != CRC_GOOD;
        end
        next_state = IN_FRAME;
        next_bitcnt = 4'h0;
        next_octcnt = 8'h00;
        next_crc = CRC_INIT;
      end
      else if (ones != STUFF_ONES && state == IN_FRAME)
      begin
        next_octet = {1'b0, octet[7:1]};
        next_crc = crc_step(crc, 1'b0);
        next_bitcnt = bitcnt + 4'h1;
      end
    end
    if (next_bitcnt == OCTET_BITS)
    begin
      next_bitcnt = 4'h0;
      next_crc_oct = next_crc;
      if (octcnt != 8'hFF)
        next_octcnt = octcnt + 8'h01;
      if (octcnt == HDR_CR_OCT - 8'h01)
        next_cr = next_octet[HDR_CR_BIT];
      if (octcnt == HDR_KIND_OCT - 8'h01)
      begin
        hdr_done = 1'b1;
        next_kind = message_kind_e'(next_octet[1:0]);
        next_eom = 1'b0;
        next_abort = 1'b0;
      end
    end
  end

  // register port
  always_comb
  begin
    next_src_nr = src_nr;
    next_rx_en = rx_en;
    next_irq_en = irq_en;
    next_irq_flag = irq_flag;
    next_rdata = RESET_BYTE;
    if (req_i.wr && addr_hit(req_i, ADDR_CTRL))
    begin
      next_src_nr = req_i.wdata[CTL_SRC];
      next_rx_en = req_i.wdata[CTL_EN];
      next_irq_en = req_i.wdata[CTL_IE];
    end
    if (req_i.rd)
    begin
      unique case (req_i.addr)
        ADDR_CTRL:
        begin
          next_rdata[CTL_SRC] = src_nr;
          next_rdata[CTL_EN] = rx_en;
          next_rdata[CTL_IE] = irq_en;
          next_rdata[CTL_IRQ] = irq_flag;
          next_irq_flag = 1'b0;
        end
        ADDR_STAT:
        begin
          next_rdata[ST_ABORT] = abort;
          next_rdata[ST_KIND+:2] = kind;
          next_rdata[ST_CR] = cr;
          next_rdata[ST_FCS] = fcs_err;
          next_rdata[ST_EOM] = message_done;
          next_rdata[ST_FLAG] = flag_seen;
        end
        ADDR_NR: next_rdata = nr_cap;
        ADDR_GC: next_rdata = gc_cap;
        ADDR_TT0: next_rdata = tt0;
        ADDR_TT1: next_rdata = tt1;
        default: next_rdata = RESET_BYTE;
      endcase
    end
    if (msg_end)
      next_irq_flag = 1'b1;
    next_irq_q = next_irq_flag && next_irq_en;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= HUNT;
      src_nr <= 1'b0;
      rx_en <= 1'b0;
      irq_en <= 1'b0;
      irq_flag <= 1'b0;
      abort <= 1'b0;
      kind <= KIND_CL_PATH;
      cr <= 1'b0;
      fcs_err <= 1'b0;
      message_done <= 1'b0;
      flag_seen <= 1'b0;
      nr_cap <= RESET_BYTE;
      gc_cap <= RESET_BYTE;
      tt0 <= RESET_BYTE;
      tt1 <= RESET_BYTE;
      tt_pos <= TT_FIRST;
      shreg <= RESET_BYTE;
      shcnt <= 4'h0;
      ones <= 3'h0;
      octet <= RESET_BYTE;
      bitcnt <= 4'h0;
      octcnt <= 8'h00;
      crc <= CRC_INIT;
      crc_oct <= CRC_INIT;
      rdata <= RESET_BYTE;
      irq_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      src_nr <= next_src_nr;
      rx_en <= next_rx_en;
      irq_en <= next_irq_en;
      irq_flag <= next_irq_flag;
      abort <= next_abort;
      kind <= next_kind;
      cr <= next_cr;
      fcs_err <= next_fcs_err;
      message_done <= next_eom;
      flag_seen <= next_flag_seen;
      nr_cap <= next_nr_cap;
      gc_cap <= next_gc_cap;
      tt0 <= next_tt0;
      tt1 <= next_tt1;
      tt_pos <= next_tt_pos;
      shreg <= next_shreg;
      shcnt <= next_shcnt;
      ones <= next_ones;
      octet <= next_octet;
      bitcnt <= next_bitcnt;
      octcnt <= next_octcnt;
      crc <= next_crc;
      crc_oct <= next_crc_oct;
      rdata <= next_rdata;
      irq_q <= next_irq_q;
    end
  end

  assign rdata_o = rdata;
  assign irq_o = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic accept;
  logic tt_armed, next_tt_armed;
  assign accept = ovh_i.valid && shcnt == 4'h0;

  // marker seen in the last accepted frame
  always_comb
  begin
    next_tt_armed = tt_armed;
    if (accept)
      next_tt_armed = ovh_i.tr[TT_MARK_BIT];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tt_armed <= 1'b0;
    else
      tt_armed <= next_tt_armed;
  end

  AST_SRC_NR: assert property (
    accept && src_nr |=> shreg == $past(ovh_i.nr))
    else $error("link byte not taken from operator byte");
  AST_DISABLED: assert property (
    !rx_en ##1 !rx_en |-> state == HUNT && !msg_end)
    else $error("receiver active while disabled");
  AST_IRQ_GATE: assert property (
    !irq_en ##1 !irq_en |-> !irq_o)
    else $error("interrupt seen while disabled");
  AST_IRQ_SET: assert property (
    msg_end && irq_en && !(req_i.wr && addr_hit(req_i, ADDR_CTRL))
    |=> irq_flag && irq_o)
    else $error("completed message did not raise interrupt");
  AST_IRQ_CLR: assert property (
    req_i.rd && addr_hit(req_i, ADDR_CTRL) && !msg_end
    |=> !irq_flag ##1 !irq_o || irq_flag)
    else $error("control read did not clear status");
  AST_ABORT: assert property (
    rx_en && bit_take && shreg[0] && ones == FLAG_ONES
    |=> abort && state == HUNT)
    else $error("abort not reported");
  AST_EOM_SET: assert property (
    msg_end |=> message_done && octcnt == 8'h00)
    else $error("end of message not set");
  AST_EOM_CLR: assert property (
    hdr_done |=> !message_done && octcnt == HDR_KIND_OCT)
    else $error("end of message not cleared by header");
  AST_FLAG: assert property (
    accept |=> flag_seen == ($past(sel_byte) == FLAG_OCTET))
    else $error("flag present wrong");
  AST_NR_READ: assert property (
    req_i.rd && addr_hit(req_i, ADDR_NR) |=> rdata_o == $past(nr_cap))
    else $error("operator byte read back wrong");
  AST_NR: assert property (
    accept |=> nr_cap == $past(ovh_i.nr))
    else $error("operator byte capture wrong");
  AST_GC: assert property (
    accept |=> gc_cap == $past(ovh_i.gc))
    else $error("general byte capture wrong");
  AST_TT0: assert property (
    accept && ovh_i.tr[TT_MARK_BIT] |=> tt0 == $past(ovh_i.tr))
    else $error("trail trace start marker wrong");
  AST_TT1: assert property (
    accept && tt_armed && !ovh_i.tr[TT_MARK_BIT]
    |=> tt1 == $past(ovh_i.tr))
    else $error("trail trace second byte wrong");

  COV_MSG_GOOD: cover property (msg_end && crc_oct == CRC_GOOD);
  COV_MSG_BAD: cover property (msg_end && crc_oct != CRC_GOOD);
  COV_ABORT: cover property (!abort ##1 abort);
  COV_TT1: cover property (accept && tt_pos == TT_SECOND);
endmodule

// >>> dv/lapd_far_end.sv
// far-end link transmitter model: hdlc frames carried in overhead bytes
module lapd_far_end
  import e3_lapd_pkg::*;
(
  input wire logic clk_i,
  output e3_overhead_s ovh_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic to_nr = 1'b0;
  logic [7:0] tr_next = 8'h00;
  logic [7:0] oct;
  logic bits[$];
  int ones = 0;
  initial ovh_o = '0;
  // one octet per frame, ten cycles apart; other byte carries the inverse
  task automatic send_octet(input logic [7:0] b);
    @(posedge clk_i);
    ovh_o <= '{1'b1, to_nr ? b : ~b, to_nr ? ~b : b, tr_next};
    @(posedge clk_i);
    ovh_o.valid <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic flush();
    while (bits.size() >= 8)
    begin
      for (int i = 0; i < 8; i++)
        oct[i] = bits.pop_front();
      send_octet(oct);
    end
  endtask
  // lsb first, zero inserted after five ones inside frames
  task automatic push_byte(input logic [7:0] b, input logic stuff);
    for (int i = 0; i < 8; i++)
    begin
      bits.push_back(b[i]);
      ones = (b[i] && stuff) ? ones + 1 : 0;
      if (ones == 5)
      begin
        bits.push_back(1'b0);
        ones = 0;
      end
    end
    flush();
  endtask
  // flag, body, check sequence, flag; bad corrupts the check sequence
  task automatic send_msg(input logic [7:0] m[$], input logic bad);
    logic [15:0] crc;
    crc = CRC_INIT;
    push_byte(FLAG_OCTET, 1'b0);
    foreach (m[i])
    begin
      push_byte(m[i], 1'b1);
      for (int k = 0; k < 8; k++)
        crc = (crc[0] ^ m[i][k]) ? (crc >> 1) ^ CRC_POLY : crc >> 1;
    end
    crc = ~crc ^ {15'h0, bad};
    push_byte(crc[7:0], 1'b1);
    push_byte(crc[15:8], 1'b1);
    push_byte(FLAG_OCTET, 1'b0);
    while (bits.size() % 8 != 0)
      bits.push_back(1'b0);
    flush();
  endtask
endmodule

// >>> dv/tb_e3_rx_lapd_overhead_capture.sv
// testbench: register checks and link messages via the far-end model
module tb_e3_rx_lapd_overhead_capture
  import e3_lapd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  reg_req_s req_i = '0;
  e3_overhead_s ovh_i;
  logic [7:0] rdata_o;
  logic irq_o;
  int n_errors = 0;
  int checked = 0;
  e3_rx_lapd_overhead_capture e3_rx_lapd_overhead_capture_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .ovh_i(ovh_i), .req_i(req_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
  lapd_far_end lapd_far_end_inst (.clk_i(clk_i), .ovh_o(ovh_i));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input string name, input logic [7:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp, input string name,
                    input logic [7:0] msk = 8'hFF);
    @(posedge clk_i);
    req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1 chk(name, exp & msk, rdata_o & msk);
  endtask
  task automatic run_msg(input logic [3:0] ctl, input logic [1:0] kind,
                         input logic cr, bad);
    logic [7:0] m[$];
    m = '{{6'h0, cr, 1'b0}, 8'h00, 8'h00, {6'h0, kind}, 8'hFF, 8'hFF};
    wr(ADDR_CTRL, {4'h0, ctl});
    lapd_far_end_inst.to_nr = ctl[3];
    lapd_far_end_inst.send_msg(m, bad);
    if (ctl[2])
      rd(ADDR_STAT, {2'b00, kind, cr, bad, 2'b10},
         "status", 8'h7E);
    else
      #1;
    chk("irq out", {7'h0, ctl[2] & ctl[1]}, {7'h0, irq_o});
    rd(ADDR_CTRL, {4'h0, ctl[3:1], ctl[2]}, "irq flag set");
    rd(ADDR_CTRL, {4'h0, ctl[3:1], 1'b0}, "irq flag clear");
    chk("irq out clear", 8'h00, {7'h0, irq_o});
  endtask
  task automatic t_reset();
    for (int a = 8'h17; a <= 8'h1E; a++)
      rd(8'(a), RESET_BYTE, "reset value");
    chk("irq reset", 8'h00, {7'h0, irq_o});
  endtask
  task automatic t_captures();
    wr(ADDR_NR, 8'h5A);
    lapd_far_end_inst.to_nr = 1'b1;
    lapd_far_end_inst.tr_next = 8'hC5;
    lapd_far_end_inst.send_octet(8'h96);
    lapd_far_end_inst.tr_next = 8'h41;
    lapd_far_end_inst.send_octet(8'h3C);
    rd(ADDR_NR, 8'h3C, "nr capture");
    rd(ADDR_GC, 8'hC3, "gc capture");
    rd(ADDR_TT0, 8'hC5, "trace first");
    rd(ADDR_TT1, 8'h41, "trace second");
  endtask
  task automatic t_flag();
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, 8'h0E, "control bits");
    wr(ADDR_CTRL, 8'h0C);
    lapd_far_end_inst.send_octet(FLAG_OCTET);
    rd(ADDR_STAT, 8'h01, "flag in nr", 8'h01);
    wr(ADDR_CTRL, 8'h04);
    lapd_far_end_inst.send_octet(FLAG_OCTET);
    rd(ADDR_STAT, 8'h00, "flag not in gc", 8'h01);
    lapd_far_end_inst.to_nr = 1'b0;
    lapd_far_end_inst.send_octet(FLAG_OCTET);
    rd(ADDR_STAT, 8'h01, "flag in gc", 8'h01);
  endtask
  task automatic t_kinds();
    for (int k = 0; k < 4; k++)
      run_msg({k[0], 3'b110}, 2'(k), ~k[0], k == 2);
  endtask
  task automatic t_gates();
    run_msg(4'hA, 2'h1, 1'b1, 1'b0);
    run_msg(4'hC, 2'h2, 1'b0, 1'b0);
  endtask
  task automatic t_abort();
    wr(ADDR_CTRL, 8'h0C);
    lapd_far_end_inst.to_nr = 1'b1;
    lapd_far_end_inst.send_octet(8'hFF);
    rd(ADDR_STAT, 8'h40, "abort seen", 8'h40);
    run_msg(4'hE, 2'h3, 1'b1, 1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_captures();
    t_flag();
    t_kinds();
    t_gates();
    t_abort();
    summarize();
  end
endmodule
